// ### include/flash_seq_pkg.sv
// constants and types shared by the flash row write sequencer
`default_nettype none
package flash_seq_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
	localparam logic [7:0] OFS_WORD_LOW = 8'h08;
	localparam logic [7:0] OFS_WORD_HIGH = 8'h0C;
	localparam logic [7:0] OFS_CONTROL = 8'h10;
	localparam logic [7:0] OFS_UNLOCK = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// control register field positions
	localparam int CTL_START = 0;
	localparam int CTL_PERMIT = 2;
	localparam int CTL_ERASE = 4;
	localparam int CTL_LATCH_ONLY = 5;
	localparam int CTL_CFG_SEL = 6;
	// status register field positions
	localparam int STS_BUSY = 0;
	localparam int STS_ABORT = 1;
	localparam int STS_IDX_LSB = 3;
	// unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// latch geometry and reset values
	localparam int LATCH_COUNT = 32;
	localparam int WORD_W = 14;
	localparam int IDX_W = 5;
	localparam int ROW_W = 10;
	localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [IDX_W-1:0] LAST_IDX = 5'h1F;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_PROG = 2'b01,
		S_ERASE = 2'b10,
		S_BLANK = 2'b11
	} seq_state_t;
endpackage
`default_nettype wire

// ### include/latch_if.sv
// carrier between the sequencer and its write latch bank
`timescale 1ns/1ps
`default_nettype none
interface latch_if #(parameter int N = 32, parameter int W = 14);
	logic load;
	logic [$clog2(N)-1:0] load_idx;
	logic [W-1:0] load_word;
	logic blank;
	logic [$clog2(N)-1:0] rd_idx;
	logic [W-1:0] rd_word;
	logic all_blank;
	modport owner(output load, load_idx, load_word, blank, rd_idx, input rd_word, all_blank);
	modport bank(input load, load_idx, load_word, blank, rd_idx, output rd_word, all_blank);
endinterface
`default_nettype wire

// ### hw/write_latch_bank.sv
// row-wide bank of write latches
`timescale 1ns/1ps
`default_nettype none
module write_latch_bank
	import flash_seq_pkg::*;
#(
	parameter int N = LATCH_COUNT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	latch_if.bank lat
);
	logic [WORD_W-1:0] word_q [N];

	// blank on reset and after each operation
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < N; i++) begin
			if (rst_i || lat.blank) begin
				word_q[i] <= BLANK_WORD;
			end else if (lat.load && (int'(lat.load_idx) == i)) begin
				word_q[i] <= lat.load_word;
			end
		end
	end

	assign lat.rd_word = word_q[lat.rd_idx];

	always_comb begin
		lat.all_blank = 1'b1;
		for (int i = 0; i < N; i++) begin
			if (word_q[i] != BLANK_WORD) begin
				lat.all_blank = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/unlock_tracker.sv
// two-key unlock sequence watcher on the register write stream
`timescale 1ns/1ps
`default_nettype none
module unlock_tracker
	import flash_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [7:0] offs_i,
	input wire logic [7:0] wdata_i,
	output logic fire_o,
	output logic abort_o
);
	logic [1:0] stage_q;
	logic key1, key2, start;

	assign key1 = wr_i && offs_i == OFS_UNLOCK && wdata_i == KEY_FIRST;
	assign key2 = wr_i && offs_i == OFS_UNLOCK && wdata_i == KEY_SECOND;
	assign start = wr_i && offs_i == OFS_CONTROL && wdata_i[CTL_START];
	// only the full key pair then start completes
	assign fire_o = start && stage_q == 2'd2;
	// any other write breaks a sequence in progress
	assign abort_o = wr_i && stage_q != 2'd0 && !fire_o
		&& !(stage_q == 2'd1 && key2) && !key1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage_q <= 2'd0;
		end else if (wr_i) begin
			if (key1) begin
				stage_q <= 2'd1;
			end else if (key2 && stage_q == 2'd1) begin
				stage_q <= 2'd2;
			end else begin
				stage_q <= 2'd0;
			end
		end
	end

	a_abort_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		abort_o |=> stage_q == 2'd0 && !fire_o) else $error("unlock not reset after abort");
	// a fire is preceded by both keys
	a_fire_keys: assert property (@(posedge clk_i) disable iff (rst_i)
		fire_o |-> stage_q == 2'd2 && $past(stage_q) != 2'd0) else $error("fire without keys");
endmodule
`default_nettype wire

// ### hw/flash_row_write_sequencer.sv
// row write sequencer for flash program memory with wishbone registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - starting a write never erases anything
// - erase acts on exactly one row
// - one write programs at most 32 latches
// - upper ten address bits pick the row
// - loads and writes stay inside the row
// - latches return to 3FFF after every operation
// - loads and writes need completed unlock
// - broken unlock loads and programs nothing
// - latch-only set: unlock loads addressed latch
// - latch-only clear: unlock programs whole row
module flash_row_write_sequencer
	import flash_seq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	output logic flash_wr_o,
	output logic flash_erase_o,
	output logic [IDX_W+ROW_W-1:0] flash_addr_o,
	output logic [WORD_W-1:0] flash_data_o,
	input wire logic flash_ready_i,
	output logic busy_o
);
	// ==========================================================
	// bus slave
	// ==========================================================
	logic ack_q;
	logic [31:0] rdata_q;
	logic req;
	logic wr_stb;
	logic [7:0] offs;

	assign req = cyc_i && stb_i && !ack_q;
	assign wr_stb = req && we_i && sel_i[0];
	assign offs = 8'(adr_i);
	assign ack_o = ack_q;
	assign dat_o = rdata_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// ==========================================================
	// software registers
	// ==========================================================
	logic [7:0] addr_low_q;
	logic [6:0] addr_high_q;
	logic [7:0] word_low_q;
	logic [5:0] word_high_q;
	logic permit_q, latch_only_q, erase_q, cfg_q, abort_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_low_q <= REG_RESET;
			addr_high_q <= 7'(REG_RESET);
		end else if (wr_stb && offs == OFS_ADDR_LOW) begin
			addr_low_q <= dat_i[7:0];
		end else if (wr_stb && offs == OFS_ADDR_HIGH) begin
			addr_high_q <= dat_i[6:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_low_q <= REG_RESET;
			word_high_q <= 6'(REG_RESET);
		end else if (wr_stb && offs == OFS_WORD_LOW) begin
			word_low_q <= dat_i[7:0];
		end else if (wr_stb && offs == OFS_WORD_HIGH) begin
			word_high_q <= dat_i[5:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			permit_q <= 1'b0;
			latch_only_q <= 1'b0;
			erase_q <= 1'b0;
			cfg_q <= 1'b0;
		end else if (wr_stb && offs == OFS_CONTROL) begin
			permit_q <= dat_i[CTL_PERMIT];
			latch_only_q <= dat_i[CTL_LATCH_ONLY];
			erase_q <= dat_i[CTL_ERASE];
			cfg_q <= dat_i[CTL_CFG_SEL];
		end
	end

	// ==========================================================
	// unlock and start decision
	// ==========================================================
	logic unlock_fire, unlock_abort, go;
	seq_state_t state_q;

	unlock_tracker u_unlock (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_stb),
		.offs_i(offs),
		.wdata_i(dat_i[7:0]),
		.fire_o(unlock_fire),
		.abort_o(unlock_abort)
	);

	assign go = unlock_fire && permit_q && !cfg_q && state_q == S_IDLE;

	// sticky broken-sequence flag, set wins over the read clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_q <= 1'b0;
		end else if (unlock_abort) begin
			abort_q <= 1'b1;
		end else if (req && !we_i && offs == OFS_STATUS) begin
			abort_q <= 1'b0;
		end
	end

	// ==========================================================
	// write latches
	// ==========================================================
	latch_if #(.N(LATCH_COUNT), .W(WORD_W)) lat ();
	logic [ROW_W-1:0] row_q;
	logic [IDX_W-1:0] widx_q;

	write_latch_bank #(.N(LATCH_COUNT)) u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.lat(lat)
	);

	// low five bits pick the latch
	// load on unlock, latch-only or final word
	// final word is loaded as the row commits
	assign lat.load = go && !erase_q;
	assign lat.load_idx = addr_low_q[IDX_W-1:0];
	assign lat.load_word = {word_high_q, word_low_q};
	assign lat.blank = state_q == S_BLANK;
	assign lat.rd_idx = widx_q;

	// ==========================================================
	// operation sequencer
	// ==========================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (go && erase_q) begin
						state_q <= S_ERASE;
					end else if (go && !latch_only_q) begin
						state_q <= S_PROG;
					end
				end
				S_PROG: begin
					if (flash_ready_i && widx_q == LAST_IDX) begin
						state_q <= S_BLANK;
					end
				end
				S_ERASE: begin
					if (flash_ready_i) begin
						state_q <= S_BLANK;
					end
				end
				S_BLANK: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// upper ten bits pick the row
	// row is frozen for the whole operation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			row_q <= '0;
		end else if (go) begin
			row_q <= {addr_high_q, addr_low_q[7:IDX_W]};
		end
	end

	// word index walks the row without carry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			widx_q <= '0;
		end else if (go) begin
			widx_q <= '0;
		end else if (state_q == S_PROG && flash_ready_i && widx_q != LAST_IDX) begin
			widx_q <= widx_q + 5'h01;
		end
	end

	assign flash_wr_o = state_q == S_PROG;
	assign flash_erase_o = state_q == S_ERASE;
	assign flash_addr_o = {row_q, widx_q};
	assign flash_data_o = lat.rd_word;
	// busy until latches are blank again
	assign busy_o = state_q != S_IDLE;

	// ==========================================================
	// read back
	// ==========================================================
	logic [7:0] ctl_rd, sts_rd;

	always_comb begin
		ctl_rd = 8'h00;
		ctl_rd[CTL_PERMIT] = permit_q;
		ctl_rd[CTL_ERASE] = erase_q;
		ctl_rd[CTL_LATCH_ONLY] = latch_only_q;
		ctl_rd[CTL_CFG_SEL] = cfg_q;
		sts_rd = 8'h00;
		sts_rd[STS_BUSY] = busy_o;
		sts_rd[STS_ABORT] = abort_q;
		sts_rd[STS_IDX_LSB +: IDX_W] = widx_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (req && !we_i) begin
			unique case (offs)
				OFS_ADDR_LOW: rdata_q <= {24'h000000, addr_low_q};
				OFS_ADDR_HIGH: rdata_q <= {25'h0000000, addr_high_q};
				OFS_WORD_LOW: rdata_q <= {24'h000000, word_low_q};
				OFS_WORD_HIGH: rdata_q <= {26'h0000000, word_high_q};
				OFS_CONTROL: rdata_q <= {24'h000000, ctl_rd};
				OFS_STATUS: rdata_q <= {24'h000000, sts_rd};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	logic [5:0] prog_cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || go) begin
			prog_cnt_q <= 6'h00;
		end else if (flash_wr_o && flash_ready_i) begin
			prog_cnt_q <= prog_cnt_q + 6'h01;
		end
	end

	sequence s_commit_start;
		go && !latch_only_q && !erase_q;
	endsequence
	sequence s_row_end;
		state_q == S_BLANK ##1 state_q == S_IDLE;
	endsequence

	sequence s_erase_start;
		go && erase_q;
	endsequence

	a_no_auto_erase: assert property (@(posedge clk_i) disable iff (rst_i)
		s_commit_start |=> flash_wr_o && !flash_erase_o) else $error("erase during program");
	a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == S_IDLE |-> !flash_wr_o && !flash_erase_o)
		else $error("flash strobe while idle");
	a_erase_one_row: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(flash_erase_o) |=> $stable(flash_addr_o) && flash_addr_o[IDX_W-1:0] == 5'h00)
		else $error("erase row moved");
	a_erase_start: assert property (@(posedge clk_i) disable iff (rst_i)
		s_erase_start |-> !lat.load ##1 flash_erase_o && !flash_wr_o)
		else $error("erase start wrong");
	a_word_count: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(flash_wr_o) |-> prog_cnt_q == 6'd32) else $error("row word count wrong");
	a_row_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_wr_o && $past(flash_wr_o) |-> flash_addr_o[IDX_W+ROW_W-1:IDX_W]
		== $past(flash_addr_o[IDX_W+ROW_W-1:IDX_W])) else $error("row changed mid write");
	a_step_row: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_wr_o && flash_ready_i && widx_q != LAST_IDX |=> flash_addr_o
		== $past(flash_addr_o) + 15'h0001) else $error("word step wrong");
	a_blank_after: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == S_BLANK |=> lat.all_blank) else $error("latches not blank");
	a_blank_once: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == S_BLANK |=> state_q == S_IDLE && !busy_o) else $error("blank cycle wrong");
	a_load_unlocked: assert property (@(posedge clk_i) disable iff (rst_i)
		lat.load |-> unlock_fire && permit_q) else $error("load without unlock");
	a_cfg_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		unlock_fire && cfg_q |-> !go && !lat.load) else $error("start with config select");
	a_abort_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		unlock_abort |-> !lat.load ##1 ($stable(state_q) || $past(state_q) != S_IDLE))
		else $error("action on broken unlock");
	a_latch_only: assert property (@(posedge clk_i) disable iff (rst_i)
		go && latch_only_q && !erase_q |=> state_q == S_IDLE && !flash_wr_o)
		else $error("latch-only programmed");
	a_only_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
		lat.load && latch_only_q |=> !lat.blank) else $error("latch-only load blanked");
	a_commit_row: assert property (@(posedge clk_i) disable iff (rst_i)
		s_commit_start |=> state_q == S_PROG && flash_addr_o[IDX_W-1:0] == 5'h00)
		else $error("commit did not start");
	a_permit_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		unlock_fire && !permit_q |=> ($stable(state_q) && busy_o == $past(busy_o))
		|| $past(state_q) != S_IDLE) else $error("unlock acted without permit");
	a_busy_until: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(busy_o) |-> $past(lat.blank) ##0 lat.all_blank) else $error("busy dropped early");
	a_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o && !lat.blank |=> busy_o) else $error("busy dropped before blank");
	a_row_end: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(flash_wr_o) |-> s_row_end) else $error("row end out of order");
endmodule
`default_nettype wire

// ### dv/flash_array_model.sv
// behavioural flash program memory array on the sequencer's far side
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic erase_i,
	input wire logic [14:0] addr_i,
	input wire logic [13:0] data_i,
	input wire logic slow_i,
	output logic ready_o
);
	logic [13:0] mem [0:32767];
	logic [15:0] lfsr_q;
	logic ok_q;
	logic [4:0] next_idx_q;
	int wr_count;
	int erase_count;
	int faults;

	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = 14'h3FFF;
		end
		wr_count = 0;
		erase_count = 0;
		faults = 0;
	end

	// ==========================================
	// handshake: prompt, or stalling at random when slow
	assign ready_o = (wr_i | erase_i) & ok_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			lfsr_q <= 16'hACE1;
			ok_q <= 1'b1;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			ok_q <= slow_i ? lfsr_q[0] : 1'b1;
		end
	end

	// ==========================================
	// array contents
	always @(posedge clk_i) begin
		if (rst_i) begin
			next_idx_q <= 5'h00;
		end else if (wr_i && ready_o) begin
			if (addr_i[4:0] !== next_idx_q) begin
				faults++;
			end
			if (mem[addr_i] !== 14'h3FFF) begin
				faults++;
			end
			mem[addr_i] <= data_i;
			next_idx_q <= next_idx_q + 5'h01;
			wr_count++;
		end else if (erase_i && ready_o) begin
			if (addr_i[4:0] !== 5'h00) begin
				faults++;
			end
			for (int i = 0; i < 32; i++) begin
				mem[{addr_i[14:5], 5'(i)}] <= 14'h3FFF;
			end
			erase_count++;
		end
	end
endmodule
`default_nettype wire

// ### dv/flash_row_write_sequencer_tb.sv
// self-checking bench for the flash row write sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_row_write_sequencer_tb
	import flash_seq_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i, we_i, cyc_i, stb_i, ack_o, slow_q;
	logic flash_wr_o, flash_erase_o, flash_ready_i, busy_o;
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [3:0] sel_i;
	logic [3:0] wsel = 4'hF;
	logic [14:0] flash_addr_o;
	logic [13:0] flash_data_o, keep;
	logic [13:0] exp_q [0:31];
	logic [9:0] row_a, row_b;
	// xorshift seed 86997
	logic [31:0] seed_q = 32'h000153D5;
	int fails = 0;
	int total_checks = 0;
	int cyc_cnt = 0;
	int wc, ec;

	always #25 clk_i = ~clk_i;

	flash_row_write_sequencer #(.ADDR_W(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.ack_o(ack_o), .flash_wr_o(flash_wr_o), .flash_erase_o(flash_erase_o),
		.flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o),
		.flash_ready_i(flash_ready_i), .busy_o(busy_o));

	flash_array_model i_flash (.clk_i(clk_i), .rst_i(rst_i), .wr_i(flash_wr_o),
		.erase_i(flash_erase_o), .addr_i(flash_addr_o), .data_i(flash_data_o),
		.slow_i(slow_q), .ready_o(flash_ready_i));

	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed_q = seed_q ^ (seed_q << 13);
		seed_q = seed_q ^ (seed_q >> 17);
		seed_q = seed_q ^ (seed_q << 5);
		return seed_q;
	endfunction

	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			fails++;
			test_done();
		end
	end

	// ==========================================
	// wishbone classic master
	task automatic wb_xfer(input logic w, input logic [7:0] offs, input logic [7:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= offs;
		sel_i <= wsel;
		dat_i <= {seed_q[31:8], d};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] offs, input logic [7:0] d);
		wb_xfer(1'b1, offs, d, rd);
	endtask

	task automatic load(input logic [9:0] row, input logic [4:0] idx, input logic [13:0] w,
		input logic [7:0] ctl, input bit brk);
		wr(OFS_ADDR_HIGH, {1'b0, row[9:3]});
		wr(OFS_ADDR_LOW, {row[2:0], idx});
		wr(OFS_WORD_LOW, w[7:0]);
		wr(OFS_WORD_HIGH, {2'b00, w[13:8]});
		wr(OFS_CONTROL, ctl);
		wr(OFS_UNLOCK, KEY_FIRST);
		if (brk) begin
			wr(OFS_WORD_LOW, 8'h00);
		end
		wr(OFS_UNLOCK, KEY_SECOND);
		wr(OFS_CONTROL, ctl | 8'h01);
	endtask

	task automatic wait_idle();
		rd = 32'h1;
		for (int n = 0; n < 500 && rd[0] !== 1'b0; n++) begin
			wb_xfer(1'b0, OFS_STATUS, 8'h00, rd);
		end
		check(rd & 32'h1, 32'h0);
		check({31'h0, busy_o}, 32'h0);
	endtask

	// ==========================================
	// random latch fill, then commit of the row
	task automatic program_row(input logic [9:0] row);
		logic [13:0] w;
		for (int i = 0; i < 31; i++) begin
			w = 14'(rnd());
			exp_q[i] = BLANK_WORD;
			if (i == 5) begin
				load(row, 5'(i), w, 8'h24, 1'b1);
				wb_xfer(1'b0, OFS_STATUS, 8'h00, rd);
				check(rd & 32'h3, 32'h2);
			end else if (i == 7) begin
				load(row, 5'(i), w, 8'h20, 1'b0);
			end else if (i == 9) begin
				load(row, 5'(i), w, 8'h64, 1'b0);
			end else if (seed_q[0]) begin
				load(row, 5'(i), w, 8'h24, 1'b0);
				exp_q[i] = w;
			end
		end
		w = 14'(rnd());
		exp_q[31] = w;
		wc = i_flash.wr_count;
		ec = i_flash.erase_count;
		load(row, 5'h1F, w, 8'h04, 1'b0);
		@(negedge clk_i);
		check({31'h0, busy_o}, 32'h1);
		wait_idle();
		check(i_flash.wr_count - wc, 32);
		check(i_flash.erase_count - ec, 0);
		for (int i = 0; i < 32; i++) begin
			check(i_flash.mem[{row, 5'(i)}], exp_q[i]);
		end
		check(i_flash.mem[{row + 10'h001, 5'h00}], BLANK_WORD);
	endtask

	// ==========================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		sel_i = 4'hF;
		slow_q = 1'b0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, OFS_STATUS, 8'h00, rd);
		check(rd, 32'h0);
		wb_xfer(1'b0, OFS_CONTROL, 8'h00, rd);
		check(rd, 32'h0);
		wr(8'h1C, 8'hFF);
		wb_xfer(1'b0, 8'h1C, 8'h00, rd);
		check(rd, 32'h0);
		wr(OFS_WORD_LOW, 8'h5A);
		wsel = 4'h0;
		wr(OFS_WORD_LOW, 8'hC3);
		wsel = 4'hF;
		wb_xfer(1'b0, OFS_WORD_LOW, 8'h00, rd);
		check(rd, 32'h5A);
		row_a = (10'(rnd()) & 10'h3FC) | 10'h001;
		row_b = row_a ^ 10'h200;
		program_row(row_a);
		@(posedge clk_i);
		slow_q <= 1'b1;
		program_row(row_b);
		wc = i_flash.wr_count;
		load(row_a + 10'h002, 5'h1F, 14'h0123, 8'h00, 1'b0);
		wr(OFS_CONTROL, 8'h04);
		wr(OFS_CONTROL, 8'h05);
		@(negedge clk_i);
		check({31'h0, busy_o}, 32'h0);
		check(i_flash.wr_count - wc, 0);
		keep = i_flash.mem[{row_b, 5'h1F}];
		wc = i_flash.wr_count;
		ec = i_flash.erase_count;
		load(row_a, 5'h03, 14'h0000, 8'h14, 1'b0);
		wait_idle();
		check(i_flash.erase_count - ec, 1);
		check(i_flash.wr_count - wc, 0);
		for (int i = 0; i < 32; i++) begin
			check(i_flash.mem[{row_a, 5'(i)}], BLANK_WORD);
		end
		check(i_flash.mem[{row_b, 5'h1F}], keep);
		@(posedge clk_i);
		slow_q <= 1'b0;
		program_row(row_a);
		check(i_flash.faults, 0);
		test_done();
	end
endmodule
`default_nettype wire
